// >>> core/rtcs_dev.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - correct every 20 s, or 60 s if bit0
// R2 - one step is one 16384 Hz pulse
// R3 - span follows from step times code range
// R4 - adjust divider pulses, oscillator untouched
// R5 - all zeros gives no correction
// R6 - bits 7..1 hold code reversed, msb at bit1
// R7 - codes 0..63 add, 64..127 drop 128-code
// R8 - software derives fast clock code
// R9 - software derives slow clock code
// R10 - host changes on fall, device captures on rise
// R11 - direction 1 at eighth rise: drive read data
// R12 - direction 0 at eighth rise: store write data
// R13 - host gives exactly two bytes of clocks
// R14 - under eight edges: no register action
// R15 - trim byte cleared at reset
// R16 - chip select low ends frame, releases line
// R17 - new code sampled at interval boundary
module rtcs_dev #(
    parameter int unsigned STAGE_CYCLES = rtcs_pkg::STAGE_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    rtcs_if.dev link,
    output logic [7:0] trim_q,
    output logic [7:0] free_q,
    output logic one_hz,
    output logic [5:0] sec_pos,
    output logic correcting
);
    import rtcs_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] sio_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync <= 2'b00;
            sck_sync <= 3'b111;
            sio_sync <= 2'b11;
        end else begin
            cs_sync <= {cs_sync[0], link.cs};
            sck_sync <= {sck_sync[1:0], link.sck_n};
            sio_sync <= {sio_sync[0], link.serial_data_io};
        end
    end

    // edges seen on the second and third stage only
    wire cs_act = cs_sync[1];
    wire sck_rise = cs_act & sck_sync[1] & ~sck_sync[2];
    wire sck_fall = cs_act & ~sck_sync[1] & sck_sync[2];
    wire sio_bit = sio_sync[1];

    // ----------------------------------------
    // serial port
    // ----------------------------------------
    rtcs_dev_state_type state_reg;
    logic [4:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [2:0] sel_reg;
    logic ok_reg;
    logic [7:0] trim_reg;
    logic [7:0] free_reg;
    logic sio_out_reg;
    logic sio_oe_reg;

    wire [7:0] shift_in = {shift_reg[6:0], sio_bit};
    wire in_cmd = state_reg == RTCS_DEV_CMD;
    wire in_wr = state_reg == RTCS_DEV_WR;
    wire in_rd = state_reg == RTCS_DEV_RD;
    wire cmd_done = sck_rise & in_cmd & (bit_reg == CMD_LAST_BIT);
    wire cmd_ok = shift_in[7:4] == CMD_FIXED;
    wire [2:0] cmd_sel = shift_in[3:1];
    wire cmd_rw = shift_in[0];
    wire wr_done = sck_rise & in_wr & (bit_reg == DATA_LAST_BIT);
    wire wr_trim = wr_done & ok_reg & (sel_reg == SEL_TRIM);
    wire wr_free = wr_done & ok_reg & (sel_reg == SEL_FREE);
    wire sel_trim = cmd_ok & (cmd_sel == SEL_TRIM);
    wire sel_free = cmd_ok & (cmd_sel == SEL_FREE);
    wire [7:0] rd_byte = sel_trim ? trim_reg : (sel_free ? free_reg : 8'h00);
    wire bit_sat = bit_reg == 5'h1f;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RTCS_DEV_CMD;
            bit_reg <= 5'h00;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            sel_reg <= 3'h0;
            ok_reg <= 1'b0;
        end else if (!cs_act) begin
            state_reg <= RTCS_DEV_CMD; // R16
            bit_reg <= 5'h00;
        end else begin
            if (sck_rise && !bit_sat) begin
                bit_reg <= bit_reg + 5'h01;
            end
            if (sck_rise) begin
                shift_reg <= shift_in; // R10
            end
            if (sck_fall && in_rd) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
            unique case (state_reg)
                RTCS_DEV_CMD: begin
                    if (cmd_done) begin // R14
                        sel_reg <= cmd_sel;
                        ok_reg <= cmd_ok;
                        tx_reg <= rd_byte;
                        state_reg <= cmd_rw ? RTCS_DEV_RD : RTCS_DEV_WR; // R11 R12
                    end
                end
                RTCS_DEV_RD: begin
                end
                RTCS_DEV_WR: begin
                end
                default: begin
                    state_reg <= RTCS_DEV_CMD;
                end
            endcase
        end
    end

    // line released whenever the frame is not a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sio_out_reg <= 1'b1;
            sio_oe_reg <= 1'b0;
        end else if (!cs_act || !in_rd) begin
            sio_oe_reg <= 1'b0; // R16
            sio_out_reg <= 1'b1;
        end else if (sck_fall) begin
            sio_out_reg <= tx_reg[7]; // R11
            sio_oe_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_reg <= TRIM_RESET; // R15
            free_reg <= FREE_RESET;
        end else begin
            if (wr_trim) begin
                trim_reg <= shift_in; // R12
            end
            if (wr_free) begin
                free_reg <= shift_in;
            end
        end
    end

    assign link.sio_d_out = sio_out_reg;
    assign link.sio_d_oe = sio_oe_reg;

    // ----------------------------------------
    // divider chain with pulse trim
    // ----------------------------------------
    logic [15:0] stage_cnt_reg;
    logic [13:0] frac_reg;
    logic [5:0] sec_reg;
    logic long_reg;
    logic signed [7:0] adj_reg;
    logic one_hz_reg;
    logic [6:0] code;

    // bit1 is the code's msb, bit7 its lsb
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_rev
            assign code[gi] = trim_reg[7 - gi]; // R6
        end
    endgenerate

    // 7-bit two's complement equals code, or code minus 128
    wire signed [7:0] adj_load = {code[6], code}; // R7 R5
    wire stage_evt = stage_cnt_reg == 16'(STAGE_CYCLES - 1);
    wire adj_pos = ~adj_reg[7] & (adj_reg != 8'sh00);
    wire adj_neg = adj_reg[7];
    // one stage pulse per interval is the resolution step
    wire [1:0] inc = adj_pos ? 2'h2 : (adj_neg ? 2'h0 : 2'h1); // R4 R2
    wire [14:0] frac_sum = {1'b0, frac_reg} + {13'h0000, inc};
    wire sec_evt = stage_evt & (frac_sum >= STAGE_PER_SEC);
    wire [5:0] sec_last = long_reg ? LAST_LONG : LAST_SHORT; // R1
    wire boundary = sec_evt & (sec_reg == sec_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_cnt_reg <= 16'h0000;
            frac_reg <= 14'h0000;
            sec_reg <= 6'h00;
            long_reg <= 1'b0;
            adj_reg <= 8'sh00;
            one_hz_reg <= 1'b0;
        end else begin
            stage_cnt_reg <= stage_evt ? 16'h0000 : stage_cnt_reg + 16'h0001;
            one_hz_reg <= sec_evt;
            if (stage_evt) begin
                frac_reg <= sec_evt ? 14'(frac_sum - STAGE_PER_SEC) : frac_sum[13:0];
            end
            if (boundary) begin
                sec_reg <= 6'h00;
                long_reg <= trim_reg[0]; // R17 R1
                adj_reg <= adj_load; // R17 R3
            end else begin
                if (sec_evt) begin
                    sec_reg <= sec_reg + 6'h01;
                end
                if (stage_evt && adj_pos) begin
                    adj_reg <= adj_reg - 8'sh01;
                end else if (stage_evt && adj_neg) begin
                    adj_reg <= adj_reg + 8'sh01;
                end
            end
        end
    end

    // ----------------------------------------
    // user side
    // ----------------------------------------
    assign trim_q = trim_reg;
    assign free_q = free_reg;
    assign one_hz = one_hz_reg;
    assign sec_pos = sec_reg;
    assign correcting = adj_reg != 8'sh00;
endmodule : rtcs_dev

// >>> core/rtcs_fifo.sv
`timescale 1ns/10ps
module rtcs_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr_reg;
    logic [AW:0] rptr_reg;

    wire full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    wire empty = wptr_reg == rptr_reg;
    wire push = in_valid & ~full;
    wire pop = out_ready & ~empty;

    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem[rptr_reg[AW-1:0]];

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_reg + (AW+1)'(push);
            rptr_reg <= rptr_reg + (AW+1)'(pop);
        end
    end
endmodule : rtcs_fifo

// >>> core/rtcs_host.sv
`timescale 1ns/10ps
module rtcs_host #(
    parameter int unsigned SCK_HALF = rtcs_pkg::SCK_HALF_DEF,
    parameter int unsigned FIFO_DEPTH = rtcs_pkg::FIFO_DEPTH_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    rtcs_if.host link
);
    import rtcs_pkg::*;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [CMD_W-1:0] fifo_out_data;
    logic rd_valid_reg;
    logic [7:0] rdata_reg;
    rtcs_host_state_type state_reg;
    logic [31:0] prdata_reg;

    wire access = psel & penable;
    wire setup = psel & ~penable;
    wire sel_cmd = paddr == HOST_CMD_OFF;
    wire sel_stat = paddr == HOST_STAT_OFF;
    wire sel_rdata = paddr == HOST_RDATA_OFF;
    wire mapped = sel_cmd | sel_stat | sel_rdata;
    wire cmd_wr = access & pwrite & sel_cmd;
    wire push = cmd_wr & fifo_in_ready;
    wire rdata_rd = access & ~pwrite & sel_rdata;
    wire busy = (state_reg != RTCS_HOST_IDLE) | fifo_out_valid;
    wire [31:0] stat_word = {28'h0000000, busy, rd_valid_reg, ~fifo_in_ready, ~fifo_out_valid};

    // full queue stalls the bus instead of losing a command
    assign pready = ~(cmd_wr & ~fifo_in_ready);
    assign pslverr = access & ~mapped;
    wire [31:0] rd_word = sel_stat ? stat_word : (sel_rdata ? {24'h000000, rdata_reg} : 32'h00000000);
    assign prdata = prdata_reg;

    // word latched in the setup cycle, so the access phase still needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (setup) begin
            prdata_reg <= rd_word;
        end
    end

    wire pop = (state_reg == RTCS_HOST_IDLE) & fifo_out_valid;

    rtcs_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) rtcs_fifo_inst (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[CMD_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    logic [7:0] half_reg;
    logic [3:0] bit_reg;
    logic [CMD_W-1:0] word_reg;
    logic [7:0] rx_reg;
    logic [1:0] sio_sync;

    wire rw = word_reg[CMD_RW_BIT];
    wire half_end = half_reg == 8'(SCK_HALF - 1);
    wire last_bit = bit_reg == DATA_LAST_BIT[3:0];
    wire [15:0] frame = {CMD_FIXED, word_reg[10:8], rw, word_reg[7:0]};
    wire [3:0] nxt_idx = (state_reg == RTCS_HOST_START) ? 4'h0 : bit_reg + 4'h1;
    wire drive_bit = frame[4'hf - nxt_idx];
    wire drive_oe = ~nxt_idx[3] | ~rw;
    wire done = (state_reg == RTCS_HOST_HIGH) & half_end & last_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sio_sync <= 2'b11;
        end else begin
            sio_sync <= {sio_sync[0], link.serial_data_io};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_valid_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (done & rw) begin
            rd_valid_reg <= 1'b1;
            rdata_reg <= rx_reg;
        end else if (rdata_rd) begin
            rd_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RTCS_HOST_IDLE;
            half_reg <= 8'h00;
            bit_reg <= 4'h0;
            word_reg <= '0;
            rx_reg <= 8'h00;
            link.cs <= 1'b0;
            link.sck_n <= 1'b1;
            link.sio_h_out <= 1'b1;
            link.sio_h_oe <= 1'b0;
        end else begin
            half_reg <= (state_reg == RTCS_HOST_IDLE || half_end) ? 8'h00 : half_reg + 8'h01;
            unique case (state_reg)
                RTCS_HOST_IDLE: begin
                    if (fifo_out_valid) begin
                        word_reg <= fifo_out_data;
                        link.cs <= 1'b1;
                        state_reg <= RTCS_HOST_START;
                    end
                end
                RTCS_HOST_START, RTCS_HOST_HIGH: begin
                    if (half_end && done) begin
                        link.cs <= 1'b0; // R16
                        link.sio_h_oe <= 1'b0;
                        state_reg <= RTCS_HOST_STOP;
                    end else if (half_end) begin
                        bit_reg <= nxt_idx;
                        link.sck_n <= 1'b0;
                        link.sio_h_out <= drive_bit; // R10
                        link.sio_h_oe <= drive_oe; // R13
                        state_reg <= RTCS_HOST_LOW;
                    end
                end
                RTCS_HOST_LOW: begin
                    if (half_end) begin
                        link.sck_n <= 1'b1;
                        if (bit_reg[3] && rw) begin
                            rx_reg <= {rx_reg[6:0], sio_sync[1]};
                        end
                        state_reg <= RTCS_HOST_HIGH;
                    end
                end
                RTCS_HOST_STOP: begin
                    if (half_end) begin
                        state_reg <= RTCS_HOST_IDLE;
                    end
                end
                default: begin
                    state_reg <= RTCS_HOST_IDLE;
                end
            endcase
        end
    end
endmodule : rtcs_host

// >>> core/rtcs_if.sv
`timescale 1ns/10ps
interface rtcs_if;
    logic cs;
    logic sck_n;
    logic sio_h_out;
    logic sio_h_oe;
    logic sio_d_out;
    logic sio_d_oe;
    wire serial_data_io;

    // pulled high when nobody drives
    assign serial_data_io = sio_d_oe ? sio_d_out : (sio_h_oe ? sio_h_out : 1'b1);

    modport host (
        output cs,
        output sck_n,
        output sio_h_out,
        output sio_h_oe,
        input serial_data_io
    );

    modport dev (
        input cs,
        input sck_n,
        input serial_data_io,
        output sio_d_out,
        output sio_d_oe
    );
endinterface : rtcs_if

// >>> core/rtcs_pkg.sv
package rtcs_pkg;
    // ----------------------------------------
    // time base
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned STAGE_HZ = 16384;
    localparam int unsigned STAGE_CYCLES_DEF = CLK_HZ / STAGE_HZ;
    localparam logic [14:0] STAGE_PER_SEC = 15'h4000;
    localparam int unsigned SECS_SHORT = 20;
    localparam int unsigned SECS_LONG = 60;
    localparam logic [5:0] LAST_SHORT = 6'(SECS_SHORT - 1);
    localparam logic [5:0] LAST_LONG = 6'(SECS_LONG - 1);

    // ----------------------------------------
    // serial frame
    // ----------------------------------------
    localparam logic [3:0] CMD_FIXED = 4'h6;
    localparam logic [2:0] SEL_TRIM = 3'h2;
    localparam logic [2:0] SEL_FREE = 3'h3;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] DATA_LAST_BIT = 5'h0f;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [7:0] FREE_RESET = 8'h00;

    // ----------------------------------------
    // host registers and queue
    // ----------------------------------------
    localparam logic [7:0] HOST_CMD_OFF = 8'h00;
    localparam logic [7:0] HOST_STAT_OFF = 8'h04;
    localparam logic [7:0] HOST_RDATA_OFF = 8'h08;
    localparam int unsigned CMD_W = 12;
    localparam int unsigned CMD_RW_BIT = 11;
    localparam int unsigned FIFO_DEPTH_DEF = 16;
    localparam int unsigned SCK_HALF_DEF = 8;

    typedef enum logic [1:0] {
        RTCS_DEV_CMD = 2'b00,
        RTCS_DEV_RD = 2'b01,
        RTCS_DEV_WR = 2'b10
    } rtcs_dev_state_type;

    typedef enum logic [2:0] {
        RTCS_HOST_IDLE = 3'b000,
        RTCS_HOST_START = 3'b001,
        RTCS_HOST_LOW = 3'b011,
        RTCS_HOST_HIGH = 3'b010,
        RTCS_HOST_STOP = 3'b110
    } rtcs_host_state_type;
endpackage : rtcs_pkg

// >>> sim/rtcs_assertions.sv
`timescale 1ns/10ps
module rtcs_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs,
    input wire logic sck_n,
    input wire logic sio_h_out,
    input wire logic sio_h_oe,
    input wire logic sio_d_out,
    input wire logic sio_d_oe,
    input wire logic serial_data_io
);
    // ----------------------------------------
    // pin-level rise count within a frame
    // ----------------------------------------
    logic sck_reg;
    logic dir_reg;
    logic [4:0] rise_reg;
    wire rise = sck_n & ~sck_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_reg <= 1'b1;
            rise_reg <= 5'h00;
            dir_reg <= 1'b0;
        end else begin
            sck_reg <= sck_n;
            if (!cs) begin
                rise_reg <= 5'h00;
            end else if (rise) begin
                rise_reg <= rise_reg + 5'h01;
            end
            if (cs && rise && rise_reg == 5'h07) begin
                dir_reg <= serial_data_io;
            end
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_idle_clock_high: assert property (!cs |-> sck_n)
        else $error("serial clock low outside a frame");
    a_host_data_hold: assert property (cs && $past(cs) && sck_n && $past(sck_n) |-> $stable(sio_h_out))
        else $error("host data moved while clock high");
    a_dev_data_hold: assert property (sio_d_oe && $past(sio_d_oe) && sck_n && $past(sck_n) |-> $stable(sio_d_out))
        else $error("device data moved while clock high");
    a_release_end: assert property ($fell(cs) |-> ##[0:6] !sio_d_oe)
        else $error("device kept the line after frame end");
    a_quiet_command: assert property (cs && rise_reg < 5'h08 |-> !sio_d_oe)
        else $error("device drove before command complete");
    a_no_clash: assert property (!(sio_d_oe && sio_h_oe))
        else $error("both ends drive the data line");
    a_read_drives: assert property (cs && dir_reg && rise_reg == 5'h08 && $fell(sck_n) |-> ##[1:6] sio_d_oe)
        else $error("device did not drive read data");
    a_write_silent: assert property (cs && !dir_reg && rise_reg >= 5'h08 |-> !sio_d_oe)
        else $error("device drove during a write");
    a_frame_bits: assert property ($fell(cs) |-> rise_reg == 5'h10)
        else $error("frame did not carry sixteen clocks");
endmodule : rtcs_assertions

// >>> sim/rtcs_bench.sv
`timescale 1ns/10ps
module rtcs_bench;
    import rtcs_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int unsigned STG = 2; // short stage so a second fits the run
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] trim_q;
    logic [7:0] free_q;
    logic [7:0] trim_b;
    logic one_hz;
    logic [5:0] sec_pos;
    logic correcting;
    logic [15:0] wire_word = 16'h0000;
    logic sck_prev = 1'b1;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    rtcs_if link();
    rtcs_if link_b();

    rtcs_host #(.SCK_HALF(8), .FIFO_DEPTH(16)) rtcs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    rtcs_dev #(.STAGE_CYCLES(STG)) rtcs_dev_inst (.pclk(pclk), .presetn(presetn), .link(link), .trim_q(trim_q),
        .free_q(free_q), .one_hz(one_hz), .sec_pos(sec_pos), .correcting(correcting));
    // second device driven by hand to break the frame rules
    rtcs_dev #(.STAGE_CYCLES(STG)) rtcs_dev_inst_b (.pclk(pclk), .presetn(presetn), .link(link_b),
        .trim_q(trim_b), .free_q(), .one_hz(), .sec_pos(), .correcting());
    rtcs_assertions rtcs_assertions_inst (.pclk(pclk), .presetn(presetn), .cs(link.cs), .sck_n(link.sck_n),
        .sio_h_out(link.sio_h_out), .sio_h_oe(link.sio_h_oe), .sio_d_out(link.sio_d_out),
        .sio_d_oe(link.sio_d_oe), .serial_data_io(link.serial_data_io));

    always #5 pclk = ~pclk;

    // bits as seen on the wire at each clock rise
    always @(posedge pclk) begin
        sck_prev <= link.sck_n;
        if (link.cs && link.sck_n && !sck_prev) begin
            wire_word <= {wire_word[14:0], link.serial_data_io};
        end
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic err, output int waits);
        waits = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            waits++;
            @(posedge pclk);
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cmd(input logic rw, input logic [2:0] sel, input logic [7:0] d, output int waits);
        logic [31:0] r;
        logic e;
        apb(1'b1, HOST_CMD_OFF, {20'h00000, rw, sel, d}, r, e, waits);
    endtask : cmd

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        int w;
        apb(1'b0, a, 32'h00000000, r, e, w);
    endtask : rd

    // waits for an empty queue and an idle engine
    task automatic settle();
        logic [31:0] r;
        rd(HOST_STAT_OFF, r);
        while (r[3] !== 1'b0 || r[0] !== 1'b1) begin
            rd(HOST_STAT_OFF, r);
        end
    endtask : settle

    task automatic bang(input logic [15:0] v, input int n);
        @(posedge pclk);
        link_b.cs <= 1'b1;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            link_b.sck_n <= 1'b0;
            link_b.sio_h_oe <= 1'b1;
            link_b.sio_h_out <= v[15-i];
            repeat (8) @(posedge pclk);
            link_b.sck_n <= 1'b1;
            repeat (8) @(posedge pclk);
        end
        link_b.cs <= 1'b0;
        link_b.sio_h_oe <= 1'b0;
        repeat (16) @(posedge pclk);
    endtask : bang

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        check("trim", 32'(TRIM_RESET), 32'(trim_q));
        check("free", 32'(FREE_RESET), 32'(free_q));
        rd(HOST_STAT_OFF, r);
        check("stat", 32'h00000001, r);
        check("idle line", 32'h1, 32'(link.serial_data_io));
    endtask : t_reset

    task automatic t_trim_rw();
        logic [31:0] r;
        int w;
        cmd(1'b0, SEL_TRIM, 8'hc6, w);
        settle();
        check("trim", 32'hc6, 32'(trim_q));
        check("wire", {16'h0, CMD_FIXED, SEL_TRIM, 1'b0, 8'hc6}, 32'(wire_word));
        cmd(1'b0, SEL_FREE, 8'h5a, w);
        cmd(1'b1, SEL_TRIM, 8'h00, w);
        settle();
        check("free", 32'h5a, 32'(free_q));
        check("wire", {16'h0, CMD_FIXED, SEL_TRIM, 1'b1, 8'hc6}, 32'(wire_word));
        rd(HOST_RDATA_OFF, r);
        check("rdata", 32'hc6, {24'h0, r[7:0]});
    endtask : t_trim_rw

    task automatic t_refuse();
        logic [31:0] r;
        logic e;
        int w;
        cmd(1'b0, 3'h5, 8'hff, w);
        cmd(1'b1, 3'h5, 8'h00, w);
        settle();
        check("trim", 32'hc6, 32'(trim_q));
        check("free", 32'h5a, 32'(free_q));
        rd(HOST_RDATA_OFF, r);
        check("rdata", 32'h0, {24'h0, r[7:0]});
        apb(1'b0, 8'h0c, 32'h0, r, e, w);
        check("unmapped err", 32'h1, 32'(e));
        check("unmapped data", 32'h0, r);
    endtask : t_refuse

    // queue fills while frames run, then stalls the bus
    task automatic t_fifo();
        logic [31:0] r;
        int w;
        for (int i = 0; i < 17; i++) begin
            cmd(1'b0, SEL_FREE, 8'(i), w);
        end
        rd(HOST_STAT_OFF, r);
        check("full", 32'h1, 32'(r[1]));
        cmd(1'b0, SEL_FREE, 8'h11, w);
        check("stalled", 32'h1, 32'(w > 0));
        settle();
        check("free last", 32'h11, 32'(free_q));
        rd(HOST_STAT_OFF, r);
        check("stat", 32'h00000001, r);
    endtask : t_fifo

    // short frames must leave no trace
    task automatic t_short();
        bang(16'h643c, 5);
        check("trim b", 32'h0, 32'(trim_b));
        bang(16'h643c, 12);
        check("trim b", 32'h0, 32'(trim_b));
        bang(16'h64f8, 16);
        check("trim b", 32'hf8, 32'(trim_b));
        check("released", 32'h0, 32'(link_b.sio_d_oe));
    endtask : t_short

    task automatic t_second();
        logic [5:0] s;
        int n;
        trim_q_zero();
        while (one_hz !== 1'b1) @(posedge pclk);
        repeat (2) @(posedge pclk);
        s = sec_pos;
        n = 2;
        do begin
            @(posedge pclk);
            n++;
        end while (one_hz !== 1'b1);
        check("second", 32'(STAGE_PER_SEC) * STG, 32'(n));
        repeat (2) @(posedge pclk);
        check("sec pos", 32'(s + 6'h01), 32'(sec_pos));
        check("correcting", 32'h0, 32'(correcting));
    endtask : t_second

    task automatic trim_q_zero();
        int w;
        cmd(1'b0, SEL_TRIM, 8'h00, w);
        settle();
    endtask : trim_q_zero

    initial begin
        link_b.cs = 1'b0;
        link_b.sck_n = 1'b1;
        link_b.sio_h_out = 1'b1;
        link_b.sio_h_oe = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_trim_rw();
        t_refuse();
        t_fifo();
        t_short();
        t_second();
        wrap_up();
    end
endmodule : rtcs_bench
